// [logic/nas_pkg.sv]
// Notes on behaviour
// - Immediate load writes its 4-bit value into the accumulator.
// - In a run of back-to-back immediate loads only the first executes.
// - Table read puts ROM bits 7..4 in upper nibble, 3..0 in accumulator.
// - Table read address is page p, table pointer bits high, accumulator low.
// - Table read holds one return-stack level while it runs.
// - Memory add sums nibble into accumulator, carry unchanged.
// - Add with carry adds nibble and carry; carry-out goes to carry flag.
// - Immediate add leaves carry; skips next unless overflow occurs.
// - Logical AND of accumulator and nibble goes to accumulator.
// - Logical OR of accumulator and nibble goes to accumulator.
// - Set carry forces carry to 1, nothing else.
// - Clear carry forces carry to 0, nothing else.
// - Carry test skips next instruction when carry is 0.
// - Complement inverts the accumulator.
// - Rotate right through carry; carry takes the bit shifted out.
// - Bit set writes 1 to selected bit of the addressed nibble.
// - Bit clear writes 0 to selected bit of the addressed nibble.
// - Bit test skips next when selected nibble bit is 0.
// - Memory compare skips next when accumulator equals nibble.
// - Immediate compare skips next when accumulator equals immediate.
package nas_pkg;

	// ----------------------------------------
	// Operation codes from the decoder
	// ----------------------------------------
	typedef enum logic [4:0] {
		NAS_OP_NONE      = 5'h00,
		NAS_OP_LOAD_IMM  = 5'h01,
		NAS_OP_TABLE     = 5'h02,
		NAS_OP_MEM_ADD   = 5'h03,
		NAS_OP_ADD_CARRY = 5'h04,
		NAS_OP_ADD_IMM   = 5'h05,
		NAS_OP_AND       = 5'h06,
		NAS_OP_OR        = 5'h07,
		NAS_OP_SET_CARRY = 5'h08,
		NAS_OP_CLR_CARRY = 5'h09,
		NAS_OP_TEST_CARRY= 5'h0A,
		NAS_OP_COMPL     = 5'h0B,
		NAS_OP_ROT_RIGHT = 5'h0C,
		NAS_OP_BIT_SET   = 5'h0D,
		NAS_OP_BIT_CLR   = 5'h0E,
		NAS_OP_BIT_TEST  = 5'h0F,
		NAS_OP_MEM_CMP   = 5'h10,
		NAS_OP_IMM_CMP   = 5'h11
	} nas_op_t;

	// ----------------------------------------
	// Table read sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		NAS_TS_IDLE = 3'h1,
		NAS_TS_WAIT = 3'h2,
		NAS_TS_DONE = 3'h4
	} nas_tstate_t;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [3:0] NAS_ACC_RST   = 4'h0;
	localparam logic [3:0] NAS_UPPER_RST = 4'h0;
	localparam logic       NAS_CARRY_RST = 1'b0;
	localparam int         NAS_ROM_WAIT  = 2;  // ROM read latency in cycles

endpackage

// [logic/nas_adder.sv]
`timescale 1ns/1ps
// 4-bit adder with carry in; carry out from bit 4
module nas_adder
	import nas_pkg::*;
(
	// Operands
	input  wire logic [3:0] a,
	input  wire logic [3:0] b,
	input  wire logic       cin,
	// Result
	output logic      [3:0] sum,
	output logic            cout
);
	logic [4:0] full;

	// Widen before adding so bit 4 holds the carry
	always_comb begin
		full = {1'b0, a} + {1'b0, b} + {4'h0, cin};
		sum  = full[3:0];
		cout = full[4];
	end
endmodule

// [logic/nas_sync2.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for a pin-level input
module nas_sync2
	import nas_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// First stage is read only by the second
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else if (ce) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// [logic/nas_alu.sv]
`timescale 1ns/1ps
// Nibble ALU with skip logic. One instruction per exec_valid pulse, except
// table read which holds busy until the ROM word returns.
module nas_alu
	import nas_pkg::*;
#(
	parameter int PAGE_W = 5
)(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Decoded instruction
	input  wire logic              exec_valid,
	input  wire nas_op_t           exec_op,
	input  wire logic [3:0]        exec_imm,
	input  wire logic [1:0]        exec_bit,
	input  wire logic [PAGE_W-1:0] exec_page,
	// Table pointer and data memory nibble
	input  wire logic [2:0]        table_pointer_bits,
	input  wire logic [3:0]        addressed_data_nibble,
	// ROM read data
	input  wire logic [7:0]        rom_data,
	// Skip-status pin from interrupt restore (asynchronous)
	input  wire logic              skip_force_pin,
	// Architectural state
	output logic      [3:0]        acc_q,
	output logic      [3:0]        upper_q,
	output logic                   carry_flag_q,
	// Data memory write
	output logic                   mem_we_q,
	output logic      [3:0]        mem_wdata_q,
	// ROM request
	output logic                   rom_req_q,
	output logic      [PAGE_W+6:0] rom_addr_q,
	// Sequencing
	output logic                   skip_next_q,
	output logic                   stack_hold_q,
	output logic                   busy_q,
	output logic                   done_q
);
	// ----------------------------------------
	// Input synchroniser and adder
	// ----------------------------------------
	logic       skip_force_s;
	logic [3:0] add_b;
	logic       add_cin;
	logic [3:0] add_sum;
	logic       add_cout;

	nas_sync2 u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.ce      (ce),
		.d       (skip_force_pin),
		.q       (skip_force_s)
	);

	nas_adder u_add (
		.a    (acc_q),
		.b    (add_b),
		.cin  (add_cin),
		.sum  (add_sum),
		.cout (add_cout)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [3:0]        acc_d, upper_d, mem_wdata_d;
	logic              carry_d, mem_we_d, skip_d, rom_req_d, hold_d, busy_d, done_d;
	logic [PAGE_W+6:0] rom_addr_d;
	logic              skipping_q, skipping_d;   // current instruction is skipped
	logic              last_load_q, last_load_d; // previous slot was a load that ran or extended a load run
	nas_tstate_t       ts_q, ts_d;
	logic [1:0]        wait_q, wait_d;
	logic [3:0]        bit_mask;
	logic              nib_bit;

	// Operand selection for the shared adder
	always_comb begin
		add_b   = (exec_op == NAS_OP_ADD_IMM) ? exec_imm : addressed_data_nibble;
		add_cin = (exec_op == NAS_OP_ADD_CARRY) ? carry_flag_q : 1'b0;
		bit_mask = 4'h1 << exec_bit;
		nib_bit  = addressed_data_nibble[exec_bit];
	end

	// Next-state for every register; skipped slots only clear the skip, update last_load_q and raise done
	always_comb begin
		acc_d       = acc_q;
		upper_d     = upper_q;
		carry_d     = carry_flag_q;
		mem_we_d    = 1'b0;
		mem_wdata_d = mem_wdata_q;
		skip_d      = 1'b0;
		rom_req_d   = 1'b0;
		rom_addr_d  = rom_addr_q;
		hold_d      = stack_hold_q;
		busy_d      = busy_q;
		done_d      = 1'b0;
		skipping_d  = skipping_q;
		last_load_d = last_load_q;
		ts_d        = ts_q;
		wait_d      = wait_q;
		case (ts_q)
		NAS_TS_IDLE: begin
			if (exec_valid) begin
				done_d = 1'b1;
				if (skipping_q || skip_force_s) begin
					skipping_d  = 1'b0;
					// A skipped load only continues an existing load run
					last_load_d = (exec_op == NAS_OP_LOAD_IMM) && last_load_q;
				end else if (exec_op == NAS_OP_LOAD_IMM && last_load_q) begin
					last_load_d = 1'b1;
				end else begin
					last_load_d = (exec_op == NAS_OP_LOAD_IMM);
					case (exec_op)
					NAS_OP_LOAD_IMM:  acc_d = exec_imm;
					NAS_OP_TABLE: begin
						rom_addr_d = {exec_page, table_pointer_bits, acc_q};
						rom_req_d  = 1'b1;
						hold_d     = 1'b1;
						busy_d     = 1'b1;
						done_d     = 1'b0;
						wait_d     = 2'(NAS_ROM_WAIT);
						ts_d       = NAS_TS_WAIT;
					end
					NAS_OP_MEM_ADD:   acc_d = add_sum;
					NAS_OP_ADD_CARRY: begin
						acc_d   = add_sum;
						carry_d = add_cout;
					end
					NAS_OP_ADD_IMM: begin
						acc_d  = add_sum;
						skip_d = ~add_cout;
					end
					NAS_OP_AND:        acc_d = acc_q & addressed_data_nibble;
					NAS_OP_OR:         acc_d = acc_q | addressed_data_nibble;
					NAS_OP_SET_CARRY:  carry_d = 1'b1;
					NAS_OP_CLR_CARRY:  carry_d = 1'b0;
					NAS_OP_TEST_CARRY: skip_d = ~carry_flag_q;
					NAS_OP_COMPL:      acc_d = ~acc_q;
					NAS_OP_ROT_RIGHT: begin
						acc_d   = {carry_flag_q, acc_q[3:1]};
						carry_d = acc_q[0];
					end
					NAS_OP_BIT_SET: begin
						mem_we_d    = 1'b1;
						mem_wdata_d = addressed_data_nibble | bit_mask;
					end
					NAS_OP_BIT_CLR: begin
						mem_we_d    = 1'b1;
						mem_wdata_d = addressed_data_nibble & ~bit_mask;
					end
					NAS_OP_BIT_TEST:  skip_d = ~nib_bit;
					NAS_OP_MEM_CMP:   skip_d = (acc_q == addressed_data_nibble);
					NAS_OP_IMM_CMP:   skip_d = (acc_q == exec_imm);
					default: ;
					endcase
					skipping_d = skip_d;
				end
			end
		end
		NAS_TS_WAIT: begin
			if (wait_q == 2'h1) begin
				ts_d = NAS_TS_DONE;
			end
			wait_d = wait_q - 2'h1;
		end
		NAS_TS_DONE: begin
			upper_d = rom_data[7:4];
			acc_d   = rom_data[3:0];
			hold_d  = 1'b0;
			busy_d  = 1'b0;
			done_d  = 1'b1;
			ts_d    = NAS_TS_IDLE;
		end
		default: ts_d = NAS_TS_IDLE;
		endcase
	end

	// Registers only; ce low freezes everything
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			acc_q        <= NAS_ACC_RST;
			upper_q      <= NAS_UPPER_RST;
			carry_flag_q <= NAS_CARRY_RST;
			mem_we_q     <= 1'b0;
			mem_wdata_q  <= 4'h0;
			rom_req_q    <= 1'b0;
			rom_addr_q   <= '0;
			skip_next_q  <= 1'b0;
			stack_hold_q <= 1'b0;
			busy_q       <= 1'b0;
			done_q       <= 1'b0;
			skipping_q   <= 1'b0;
			last_load_q  <= 1'b0;
			ts_q         <= NAS_TS_IDLE;
			wait_q       <= 2'h0;
		end else if (ce) begin
			acc_q        <= acc_d;
			upper_q      <= upper_d;
			carry_flag_q <= carry_d;
			mem_we_q     <= mem_we_d;
			mem_wdata_q  <= mem_wdata_d;
			rom_req_q    <= rom_req_d;
			rom_addr_q   <= rom_addr_d;
			skip_next_q  <= skip_d;
			stack_hold_q <= hold_d;
			busy_q       <= busy_d;
			done_q       <= done_d;
			skipping_q   <= skipping_d;
			last_load_q  <= last_load_d;
			ts_q         <= ts_d;
			wait_q       <= wait_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic idle_exec;
	assign idle_exec = ce && exec_valid && ts_q == NAS_TS_IDLE && !skipping_q
		&& !skip_force_s;

	property p_load;
		@(posedge clk_sys) disable iff (!rst_n)
		idle_exec && exec_op == NAS_OP_LOAD_IMM && !last_load_q |=> acc_q == $past(exec_imm);
	endproperty
	a_load: assert property (p_load) else $error("load value lost");

	property p_load_run;
		@(posedge clk_sys) disable iff (!rst_n)
		idle_exec && exec_op == NAS_OP_LOAD_IMM && last_load_q |=> $stable(acc_q);
	endproperty
	a_load_run: assert property (p_load_run) else $error("repeat load ran");

	sequence s_table_start;
		idle_exec && exec_op == NAS_OP_TABLE;
	endsequence
	property p_table;
		@(posedge clk_sys) disable iff (!rst_n)
		s_table_start ##1 (ce && busy_q)[*3] |=> done_q && acc_q == $past(rom_data[3:0])
			&& upper_q == $past(rom_data[7:4]);
	endproperty
	a_table: assert property (p_table) else $error("table word misplaced");

	property p_table_addr;
		@(posedge clk_sys) disable iff (!rst_n)
		s_table_start |=> rom_req_q && rom_addr_q[6:0] == {$past(table_pointer_bits), $past(acc_q)};
	endproperty
	a_table_addr: assert property (p_table_addr) else $error("table address wrong");

	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		busy_q |-> stack_hold_q;
	endproperty
	a_hold: assert property (p_hold) else $error("stack level not held");

	property p_add_carry;
		@(posedge clk_sys) disable iff (!rst_n)
		idle_exec && exec_op == NAS_OP_ADD_CARRY |=>
			{carry_flag_q, acc_q} == $past(acc_q) + $past(addressed_data_nibble)
			+ $past(carry_flag_q);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry add wrong");

	property p_add_imm;
		@(posedge clk_sys) disable iff (!rst_n)
		idle_exec && exec_op == NAS_OP_ADD_IMM |=> $stable(carry_flag_q)
			&& skip_next_q == ({1'b0, $past(acc_q)} + $past(exec_imm) < 5'h10);
	endproperty
	a_add_imm: assert property (p_add_imm) else $error("immediate add skip wrong");

	property p_rotate;
		@(posedge clk_sys) disable iff (!rst_n)
		idle_exec && exec_op == NAS_OP_ROT_RIGHT |=>
			{acc_q, carry_flag_q} == {$past(carry_flag_q), $past(acc_q)};
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate wrong");

	property p_cmp;
		@(posedge clk_sys) disable iff (!rst_n)
		idle_exec && exec_op == NAS_OP_IMM_CMP |=> skip_next_q == ($past(acc_q) == $past(exec_imm));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare skip wrong");

	property p_skipped;
		@(posedge clk_sys) disable iff (!rst_n)
		ce && exec_valid && ts_q == NAS_TS_IDLE && skipping_q |=> $stable(acc_q)
			&& $stable(carry_flag_q) && !mem_we_q && !rom_req_q;
	endproperty
	a_skipped: assert property (p_skipped) else $error("skipped op had effect");
endmodule

// [test/nas_far_model.sv]
`timescale 1ns/1ps
// Far side: the nibble at the data pointer and a table ROM
module nas_far_model
	import nas_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Bench preset of the addressed nibble
	input  wire logic        pre_en,
	input  wire logic [3:0]  pre_val,
	// Requests from the datapath
	input  wire logic        mem_we_q,
	input  wire logic [3:0]  mem_wdata_q,
	input  wire logic        rom_req_q,
	input  wire logic [11:0] rom_addr_q,
	// Answers
	output logic      [3:0]  addressed_data_nibble,
	output logic      [7:0]  rom_data
);
	logic [3:0]  nib_q;
	logic [11:0] addr_q;
	logic [1:0]  live_q;
	logic [7:0]  word;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// ROM word stays live for three cycles after the request is seen
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			nib_q <= 4'h0;
			addr_q <= 12'h000;
			live_q <= 2'h0;
		end else begin
			if (pre_en)
				nib_q <= pre_val;
			else if (mem_we_q)
				nib_q <= mem_wdata_q;
			if (rom_req_q) begin
				addr_q <= rom_addr_q;
				live_q <= 2'h3;
			end else if (live_q != 2'h0)
				live_q <= live_q - 2'h1;
		end
	end

	// Outside the live window the bus shows the inverse, so a late or
	// early sample of rom_data cannot pass by accident
	assign word = 8'h5A ^ addr_q[7:0] ^ {addr_q[11:8], 4'h0};
	assign rom_data = (live_q != 2'h0) ? word : ~word;
	assign addressed_data_nibble = nib_q;
endmodule

// [test/test_nibble_alu_skip_logic.sv]
`timescale 1ns/1ps
module test_nibble_alu_skip_logic
	import nas_pkg::*;
;
	logic clk_sys = 0, rst_n = 0, ce = 1, exec_valid = 0, pin = 0, pre_en = 0;
	nas_op_t exec_op = NAS_OP_NONE;
	logic [3:0] exec_imm = 4'h0, pre_val = 4'h0, nib, acc_q, upper_q, mem_wdata_q;
	logic [1:0] exec_bit = 2'h0;
	logic [4:0] exec_page = 5'h00;
	logic [2:0] tp = 3'h0;
	logic [7:0] rom_data;
	logic [11:0] rom_addr_q;
	logic carry_flag_q, mem_we_q, rom_req_q, skip_next_q, stack_hold_q, busy_q, done_q;
	logic [3:0] e_acc = 4'h0, e_up = 4'h0, e_mem = 4'h0;
	logic e_cy = 0, e_skip = 0, e_ld = 0, e_force = 0;
	int mismatches = 0, n_checks = 0;

	always #2.5 clk_sys = ~clk_sys;

	nas_alu DUT (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .exec_valid(exec_valid),
		.exec_op(exec_op), .exec_imm(exec_imm), .exec_bit(exec_bit), .exec_page(exec_page),
		.table_pointer_bits(tp), .addressed_data_nibble(nib), .rom_data(rom_data),
		.skip_force_pin(pin), .acc_q(acc_q), .upper_q(upper_q), .carry_flag_q(carry_flag_q),
		.mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .rom_req_q(rom_req_q),
		.rom_addr_q(rom_addr_q), .skip_next_q(skip_next_q), .stack_hold_q(stack_hold_q),
		.busy_q(busy_q), .done_q(done_q));
	nas_far_model far (.clk_sys(clk_sys), .rst_n(rst_n), .pre_en(pre_en), .pre_val(pre_val),
		.mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .rom_req_q(rom_req_q),
		.rom_addr_q(rom_addr_q), .addressed_data_nibble(nib), .rom_data(rom_data));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
		n_checks++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Preset the addressed nibble through the far-side model
	task automatic setm(input logic [3:0] v);
		@(posedge clk_sys);
		pre_en <= 1'b1;
		pre_val <= v;
		@(posedge clk_sys);
		pre_en <= 1'b0;
		e_mem = v;
	endtask

	// One instruction slot: predict, drive, wait for done, compare
	task automatic step(input nas_op_t op, input logic [3:0] imm, input logic [1:0] j);
		logic [4:0] s;
		logic [11:0] ra;
		logic [7:0] w;
		logic sk, we;
		int n;
		sk = e_skip | e_force | (op == NAS_OP_LOAD_IMM && e_ld);
		// A load in a slot skipped for another reason only extends a run
		e_ld = (op == NAS_OP_LOAD_IMM) && (!(e_skip | e_force) || e_ld);
		e_skip = 1'b0;
		we = 1'b0;
		ra = {exec_page, tp, e_acc};
		w = 8'h5A ^ ra[7:0] ^ {ra[11:8], 4'h0};
		if (!sk) begin
			case (op)
				NAS_OP_LOAD_IMM: e_acc = imm;
				NAS_OP_TABLE: {e_up, e_acc} = w;
				NAS_OP_MEM_ADD: e_acc = e_acc + e_mem;
				NAS_OP_ADD_CARRY: {e_cy, e_acc} = {1'b0, e_acc} + e_mem + e_cy;
				NAS_OP_ADD_IMM: begin
					s = {1'b0, e_acc} + {1'b0, imm};
					e_acc = s[3:0];
					e_skip = !s[4];
				end
				NAS_OP_AND: e_acc = e_acc & e_mem;
				NAS_OP_OR: e_acc = e_acc | e_mem;
				NAS_OP_SET_CARRY: e_cy = 1'b1;
				NAS_OP_CLR_CARRY: e_cy = 1'b0;
				NAS_OP_TEST_CARRY: e_skip = !e_cy;
				NAS_OP_COMPL: e_acc = ~e_acc;
				NAS_OP_ROT_RIGHT: {e_acc, e_cy} = {e_cy, e_acc};
				NAS_OP_BIT_SET: {we, e_mem[j]} = 2'b11;
				NAS_OP_BIT_CLR: {we, e_mem[j]} = 2'b10;
				NAS_OP_BIT_TEST: e_skip = !e_mem[j];
				NAS_OP_MEM_CMP: e_skip = (e_acc == e_mem);
				NAS_OP_IMM_CMP: e_skip = (e_acc == imm);
				default: ;
			endcase
		end
		@(posedge clk_sys);
		exec_valid <= 1'b1;
		exec_op <= op;
		exec_imm <= imm;
		exec_bit <= j;
		@(posedge clk_sys);
		exec_valid <= 1'b0;
		#1;
		if (op == NAS_OP_TABLE && !sk) begin
			chk("rom address", ra, rom_addr_q);
			chk("stack hold", 1, stack_hold_q);
		end
		n = 0;
		while (done_q !== 1'b1 && n < 10) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("done", 1, done_q);
		chk("acc", e_acc, acc_q);
		chk("upper", e_up, upper_q);
		chk("carry", e_cy, carry_flag_q);
		chk("skip", e_skip, skip_next_q);
		chk("mem write", we, mem_we_q);
		if (we)
			chk("mem data", e_mem, mem_wdata_q);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_loads();
		step(NAS_OP_LOAD_IMM, 4'h3, 0);
		step(NAS_OP_LOAD_IMM, 4'h7, 0);
		step(NAS_OP_LOAD_IMM, 4'h9, 0);
		step(NAS_OP_COMPL, 0, 0);
		step(NAS_OP_LOAD_IMM, 4'h9, 0);
	endtask

	task automatic t_adds();
		setm(4'hC);
		step(NAS_OP_CLR_CARRY, 0, 0);
		step(NAS_OP_LOAD_IMM, 4'h6, 0);
		step(NAS_OP_MEM_ADD, 0, 0);
		step(NAS_OP_SET_CARRY, 0, 0);
		step(NAS_OP_MEM_ADD, 0, 0);
		step(NAS_OP_ADD_CARRY, 0, 0);
		step(NAS_OP_ADD_CARRY, 0, 0);
		step(NAS_OP_ADD_IMM, 4'h2, 0);
		step(NAS_OP_ADD_IMM, 4'h5, 0);
		step(NAS_OP_ADD_IMM, 4'h7, 0);
	endtask

	task automatic t_logic();
		setm(4'hA);
		step(NAS_OP_AND, 0, 0);
		step(NAS_OP_OR, 0, 0);
		repeat (5) step(NAS_OP_ROT_RIGHT, 0, 0);
		step(NAS_OP_SET_CARRY, 0, 0);
		step(NAS_OP_TEST_CARRY, 0, 0);
		step(NAS_OP_CLR_CARRY, 0, 0);
		step(NAS_OP_TEST_CARRY, 0, 0);
		step(NAS_OP_SET_CARRY, 0, 0);
	endtask

	// Every bit index, both polarities of the bit test
	task automatic t_bits();
		for (int j = 0; j < 4; j++) begin
			setm(4'h0);
			step(NAS_OP_BIT_SET, 0, j[1:0]);
			step(NAS_OP_BIT_TEST, 0, j[1:0]);
			setm(4'hF);
			step(NAS_OP_BIT_CLR, 0, j[1:0]);
			step(NAS_OP_BIT_TEST, 0, j[1:0]);
			step(NAS_OP_BIT_SET, 0, j[1:0]);
		end
	endtask

	task automatic t_cmp();
		step(NAS_OP_LOAD_IMM, 4'h5, 0);
		setm(4'h5);
		step(NAS_OP_MEM_CMP, 0, 0);
		step(NAS_OP_COMPL, 0, 0);
		step(NAS_OP_IMM_CMP, 4'h5, 0);
		step(NAS_OP_LOAD_IMM, 4'hA, 0);
		step(NAS_OP_LOAD_IMM, 4'h6, 0);
		step(NAS_OP_IMM_CMP, 4'h5, 0);
		setm(4'h7);
		step(NAS_OP_MEM_CMP, 0, 0);
	endtask

	// Highest page and a mixed pointer, two reads back to back
	task automatic t_table();
		@(posedge clk_sys);
		tp <= 3'h5;
		exec_page <= 5'h1F;
		step(NAS_OP_LOAD_IMM, 4'hE, 0);
		step(NAS_OP_TABLE, 0, 0);
		step(NAS_OP_TABLE, 0, 0);
		chk("stack released", 0, stack_hold_q);
	endtask

	// Restored skip status turns the slot into a no-operation
	task automatic t_force();
		@(posedge clk_sys);
		pin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		e_force = 1'b1;
		step(NAS_OP_COMPL, 0, 0);
		@(posedge clk_sys);
		pin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		e_force = 1'b0;
		step(NAS_OP_COMPL, 0, 0);
	endtask

	// Clock enable low: a slot offered meanwhile leaves no trace
	task automatic t_freeze();
		@(posedge clk_sys);
		ce <= 1'b0;
		exec_valid <= 1'b1;
		exec_op <= NAS_OP_COMPL;
		repeat (3) @(posedge clk_sys);
		exec_valid <= 1'b0;
		ce <= 1'b1;
		#1;
		chk("frozen done", 0, done_q);
		chk("frozen acc", e_acc, acc_q);
		@(posedge clk_sys);
		#1;
		chk("frozen done", 0, done_q);
		chk("frozen acc", e_acc, acc_q);
	endtask

	// Mid-run reset: outputs clear, and a load run restarts afterwards
	task automatic t_reset();
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("reset acc", NAS_ACC_RST, acc_q);
		chk("reset upper", NAS_UPPER_RST, upper_q);
		chk("reset carry", NAS_CARRY_RST, carry_flag_q);
		chk("reset flags", 0, {busy_q, done_q, skip_next_q, stack_hold_q, mem_we_q});
		@(posedge clk_sys);
		rst_n <= 1'b1;
		e_acc = NAS_ACC_RST;
		e_up = NAS_UPPER_RST;
		e_cy = NAS_CARRY_RST;
		e_mem = 4'h0;
		e_skip = 1'b0;
		e_ld = 1'b0;
		step(NAS_OP_LOAD_IMM, 4'h6, 0);
		step(NAS_OP_LOAD_IMM, 4'h2, 0);
	endtask

	initial begin
		#20000;
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_loads();
		t_adds();
		t_logic();
		t_bits();
		t_cmp();
		t_table();
		t_force();
		t_freeze();
		t_reset();
		wrap_up();
	end
endmodule
